// ### core/udpb_pkg.sv
// Package for the user data partition base register block
package udpb_pkg;
  localparam int unsigned ADDR_W          = 12;
  localparam int unsigned DATA_W          = 32;
  localparam logic [11:0] OFS_PART_BASE   = 12'h000;
  localparam logic [11:0] OFS_KERN_BASE   = 12'h004;
  localparam logic [11:0] OFS_RAM_SIZE    = 12'h008;
  localparam int unsigned BASE_LSB        = 10;
  localparam int unsigned BASE_MSB        = 15;
  localparam logic [5:0]  BASE_RESET      = 6'h00;
  localparam logic [31:0] KERN_RESET      = 32'h00000000;
  localparam logic [31:0] RAM_SIZE_RESET  = 32'h00008000;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } udpb_apb_req_s;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } udpb_apb_rsp_s;

  typedef enum logic [1:0] {
    UDPB_IDLE   = 2'b01,
    UDPB_ACCESS = 2'b10
  } udpb_state_e;
endpackage

// ### core/udpb_field.sv
// Partition base field storage with the fixed low bits
`timescale 1ns/1ps
module udpb_field
  import udpb_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        wr_en,
  input  wire logic [31:0] wr_data,
  output logic      [31:0] base_word
);
  import udpb_pkg::*;

  typedef struct packed {
    logic [5:0] base;
  } udpb_field_s;

  udpb_field_s cur;
  udpb_field_s next_cur;

  always_comb begin
    next_cur = cur;
    if (wr_en) begin
      next_cur.base = wr_data[BASE_MSB:BASE_LSB];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur.base <= BASE_RESET;
    end else begin
      cur <= next_cur;
    end
  end

  // Upper bits unimplemented, low ten bits fixed zero
  assign base_word = {16'h0000, cur.base, 10'h000};

  AST_LOW_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
    base_word[9:0] == 10'h000) else $error("low bits not zero");
  AST_HIGH_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
    base_word[31:16] == 16'h0000) else $error("upper bits not zero");
  AST_WRITE_TAKES: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en |=> base_word[15:10] == $past(wr_data[15:10])) else $error("write not stored");
  AST_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    !wr_en |=> $stable(base_word)) else $error("field changed without write");
endmodule

// ### core/udpb_top.sv
// APB register slave for the user data partition base
// What this block does
// - Bits 15 to 10 are writable and, when non-zero, set the user data region start in data RAM.
// - Bits 9 to 0 always read zero so the boundary moves in 1 KB steps.
// - Any reset clears the register so all RAM belongs to kernel data.
// - Bits 31 to 16 read zero and ignore writes.
`timescale 1ns/1ps
module udpb_top
  import udpb_pkg::*;
(
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire udpb_pkg::udpb_apb_req_s apb_req,
  output udpb_pkg::udpb_apb_rsp_s      apb_rsp,
  output logic      [31:0]             user_data_partition_base,
  output logic                         user_region_active,
  output logic                         base_setting_bad
);
  import udpb_pkg::*;

  // Which of the three words a bus address selects
  typedef enum logic [3:0] {
    UDPB_SEL_NONE = 4'b0001,
    UDPB_SEL_BASE = 4'b0010,
    UDPB_SEL_KERN = 4'b0100,
    UDPB_SEL_SIZE = 4'b1000
  } udpb_sel_e;

  typedef struct packed {
    udpb_state_e   state;
    udpb_apb_rsp_s rsp;
    logic [31:0]   kern;
    logic [31:0]   ram_size;
    logic [31:0]   base;
    logic          active;
    logic          bad;
  } udpb_top_s;

  udpb_top_s   cur;
  udpb_top_s   next_cur;
  logic [31:0] base_word;
  logic        wr_base;
  logic        setup_phase;
  logic        access_done;
  udpb_sel_e   sel;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    return a == ofs;
  endfunction

  function automatic udpb_sel_e decode(input logic [11:0] a);
    if (hit(a, OFS_PART_BASE)) begin
      return UDPB_SEL_BASE;
    end
    if (hit(a, OFS_KERN_BASE)) begin
      return UDPB_SEL_KERN;
    end
    if (hit(a, OFS_RAM_SIZE)) begin
      return UDPB_SEL_SIZE;
    end
    return UDPB_SEL_NONE;
  endfunction

  function automatic logic [31:0] read_word(input udpb_sel_e   s,
                                            input logic [31:0] b,
                                            input logic [31:0] k,
                                            input logic [31:0] z);
    logic [31:0] w;
    w = 32'h00000000;
    case (s)
      UDPB_SEL_BASE: begin
        w = b;
      end
      UDPB_SEL_KERN: begin
        w = k;
      end
      UDPB_SEL_SIZE: begin
        w = z;
      end
      default: begin
        w = 32'h00000000;
      end
    endcase
    return w;
  endfunction

  // Zero base means no user region, so neither limit applies
  function automatic logic limits_broken(input logic [31:0] b,
                                         input logic [31:0] k,
                                         input logic [31:0] s);
    return (b != 32'h00000000) && ((b <= k) || (b > s));
  endfunction

  assign sel         = decode(apb_req.paddr);
  assign setup_phase = apb_req.psel && !apb_req.penable && (cur.state == UDPB_IDLE);
  // Writes land only at the edge where pready is seen high
  assign access_done = apb_req.psel && apb_req.penable && cur.rsp.pready && (cur.state == UDPB_ACCESS);
  assign wr_base     = access_done && apb_req.pwrite && (sel == UDPB_SEL_BASE);

  udpb_field u_field (
    .pclk      (pclk),
    .presetn   (presetn),
    .wr_en     (wr_base),
    .wr_data   (apb_req.pwdata),
    .base_word (base_word)
  );

  always_comb begin
    next_cur = cur;
    next_cur.rsp.pready = 1'b0;
    next_cur.rsp.pslverr = 1'b0;
    case (cur.state)
      UDPB_IDLE: begin
        if (setup_phase) begin
          next_cur.state = UDPB_ACCESS;
          next_cur.rsp.pready = 1'b1;
          next_cur.rsp.pslverr = (sel == UDPB_SEL_NONE);
          if (!apb_req.pwrite) begin
            next_cur.rsp.prdata = read_word(sel, base_word, cur.kern, cur.ram_size);
          end
        end
      end
      UDPB_ACCESS: begin
        next_cur.state = UDPB_IDLE;
        if (access_done && apb_req.pwrite) begin
          case (sel)
            UDPB_SEL_KERN: begin
              next_cur.kern = apb_req.pwdata;
            end
            UDPB_SEL_SIZE: begin
              next_cur.ram_size = apb_req.pwdata;
            end
            default: begin
              next_cur.kern = cur.kern;
            end
          endcase
        end
      end
      default: begin
        next_cur.state = UDPB_IDLE;
      end
    endcase
    next_cur.base = base_word;
    next_cur.active = base_word[15:10] != 6'h00;
    next_cur.bad = limits_broken(base_word, cur.kern, cur.ram_size);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur.state    <= UDPB_IDLE;
      cur.rsp      <= '0;
      cur.kern     <= KERN_RESET;
      cur.ram_size <= RAM_SIZE_RESET;
      cur.base     <= 32'h00000000;
      cur.active   <= 1'b0;
      cur.bad      <= 1'b0;
    end else begin
      cur <= next_cur;
    end
  end

  assign apb_rsp = cur.rsp;
  assign user_region_active = cur.active;
  assign base_setting_bad = cur.bad;
  assign user_data_partition_base = cur.base;

  // Bus handshake checks
  AST_READY_ONE: assert property (@(posedge pclk) disable iff (!presetn)
    apb_req.psel && !apb_req.penable |=> apb_rsp.pready) else $error("pready late");

  AST_READY_PULSE: assert property (@(posedge pclk) disable iff (!presetn)
    apb_rsp.pready |=> !apb_rsp.pready) else $error("pready longer than one cycle");

  AST_ERR_WITH_READY: assert property (@(posedge pclk) disable iff (!presetn)
    apb_rsp.pslverr |-> apb_rsp.pready) else $error("pslverr without pready");

  AST_UNMAPPED_ERR: assert property (@(posedge pclk) disable iff (!presetn)
    apb_req.psel && !apb_req.penable && (decode(apb_req.paddr) == UDPB_SEL_NONE) |=> apb_rsp.pslverr)
    else $error("unmapped access not refused");

  // Register content checks
  AST_READ_BACK: assert property (@(posedge pclk) disable iff (!presetn)
    apb_req.psel && !apb_req.penable && !apb_req.pwrite && hit(apb_req.paddr, OFS_PART_BASE)
    |=> apb_rsp.prdata[9:0] == 10'h000 && apb_rsp.prdata[31:16] == 16'h0000)
    else $error("read reserved bits nonzero");

  AST_ACTIVE: assert property (@(posedge pclk) disable iff (!presetn)
    user_region_active == ($past(base_word[15:10]) != 6'h00)) else $error("active wrong");

  AST_RESET_ZERO: assert property (@(posedge pclk)
    !presetn |=> user_data_partition_base == 32'h00000000) else $error("reset not zero");

  AST_OUT_FOLLOWS: assert property (@(posedge pclk) disable iff (!presetn)
    user_data_partition_base == $past(base_word)) else $error("base output lags wrong");

  AST_BASE_ONLY_AT_END: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(base_word) |-> $past(wr_base)) else $error("base changed without write");

  AST_BAD: assert property (@(posedge pclk) disable iff (!presetn)
    base_setting_bad == limits_broken($past(base_word), $past(cur.kern), $past(cur.ram_size)))
    else $error("bad flag wrong");

  AST_KERN_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    !(access_done && apb_req.pwrite && (sel == UDPB_SEL_KERN)) |=> $stable(cur.kern))
    else $error("kernel base changed without write");

  AST_SIZE_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    !(access_done && apb_req.pwrite && (sel == UDPB_SEL_SIZE)) |=> $stable(cur.ram_size))
    else $error("ram size changed without write");

  AST_KERN_READ: assert property (@(posedge pclk) disable iff (!presetn)
    setup_phase && !apb_req.pwrite && (sel == UDPB_SEL_KERN) |=> apb_rsp.prdata == $past(cur.kern))
    else $error("kernel base read wrong");

  AST_SIZE_READ: assert property (@(posedge pclk) disable iff (!presetn)
    setup_phase && !apb_req.pwrite && (sel == UDPB_SEL_SIZE) |=> apb_rsp.prdata == $past(cur.ram_size))
    else $error("ram size read wrong");

  COV_WRITE: cover property (@(posedge pclk) disable iff (!presetn) wr_base);
  COV_ACTIVE: cover property (@(posedge pclk) disable iff (!presetn) $rose(user_region_active));
  COV_BAD: cover property (@(posedge pclk) disable iff (!presetn) $rose(base_setting_bad));
  COV_READ_BASE: cover property (@(posedge pclk) disable iff (!presetn)
    setup_phase && !apb_req.pwrite && (sel == UDPB_SEL_BASE));
  COV_UNMAPPED: cover property (@(posedge pclk) disable iff (!presetn) apb_rsp.pslverr);
endmodule

// ### verif/udpb_top_tb.sv
// Self-checking bench for the user data partition base slave
`timescale 1ns/1ps
module udpb_top_tb;
  import udpb_pkg::*;
  localparam logic [31:0] MASK     = 32'h0000FC00;
  logic                   pclk     = 1'b0;
  logic                   presetn  = 1'b0;
  udpb_apb_req_s          req      = '0;
  udpb_apb_rsp_s          rsp;
  logic [31:0]            base_out;
  logic                   act;
  logic                   bad;
  logic [31:0]            rd;
  logic                   err;
  logic [31:0]            kern;
  logic [31:0]            sz;
  logic [31:0]            w;
  int                     n_errors = 0;
  int                     compares = 0;

  always #5 pclk = ~pclk;

  udpb_top i_dut (
    .pclk                     (pclk),
    .presetn                  (presetn),
    .apb_req                  (req),
    .apb_rsp                  (rsp),
    .user_data_partition_base (base_out),
    .user_region_active       (act),
    .base_setting_bad         (bad)
  );

  task report_and_stop;
    $display("comparisons %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task check(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      n_errors++;
    end
  endtask

  // One APB transfer; the idle edge first keeps back-to-back calls race free
  task xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge pclk);
    req.penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (rsp.pready !== 1'b1 && i < 20);
    if (rsp.pready !== 1'b1) begin
      n_errors++;
      report_and_stop;
    end
    rd = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask

  function automatic logic f_bad(input logic [31:0] b, input logic [31:0] k, input logic [31:0] s);
    return (b != 32'h0) && ((b <= k) || (b > s));
  endfunction

  initial begin
    void'($urandom(32'h5c7d2737));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    xfer(1'b0, OFS_PART_BASE, 32'h0);
    check("reset base", 32'h0, rd);
    check("reset active", 32'h0, {31'h0, act});
    kern = KERN_RESET;
    sz = RAM_SIZE_RESET;
    for (int n = 0; n < 40; n++) begin
      w = (n < 2) ? {32{n[0]}} : $urandom;
      if (n % 8 == 3) begin
        kern = $urandom & 32'h0000FFFF;
        sz = $urandom & 32'h0000FFFF;
        xfer(1'b1, OFS_KERN_BASE, kern);
        xfer(1'b1, OFS_RAM_SIZE, sz);
        xfer(1'b0, OFS_KERN_BASE, 32'h0);
        check("kernel base", kern, rd);
        xfer(1'b0, OFS_RAM_SIZE, 32'h0);
        check("ram size", sz, rd);
      end
      xfer(1'b1, OFS_PART_BASE, w);
      check("write err", 32'h0, {31'h0, err});
      xfer(1'b0, OFS_PART_BASE, 32'h0);
      check("base read", w & MASK, rd);
      check("base out", w & MASK, base_out);
      check("active", {31'h0, (w & MASK) != 32'h0}, {31'h0, act});
      check("bad", {31'h0, f_bad(w & MASK, kern, sz)}, {31'h0, bad});
    end
    $display("test random writes done");
    xfer(1'b1, 12'h00C, 32'hFFFFFFFF);
    check("unmapped err", 32'h1, {31'h0, err});
    xfer(1'b0, OFS_PART_BASE, 32'h0);
    check("base kept", w & MASK, rd);
    $display("test unmapped done");
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    check("reset out", 32'h0, base_out);
    presetn <= 1'b1;
    xfer(1'b0, OFS_PART_BASE, 32'h0);
    check("reset read", 32'h0, rd);
    $display("test mid reset done");
    report_and_stop;
  end
endmodule
